// file: sap_audio_serial_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "sap_params.svh"
module sap_audio_serial_unit
	import sap_pkg::*;
(
	// Clocks and reset
	input  wire logic               sys_clk_in,
	input  wire logic               reset_in,
	input  wire logic               link_clk_in,
	// Configuration
	input  wire logic               run_in,
	input  wire sap_mode_t          mode_in,
	input  wire sap_len_t           word_length_field_in,
	// Transmit words, right then left in master mode
	input  wire logic               tx_valid_in,
	input  wire logic [`SAP_DW-1:0] tx_data_in,
	output logic                    tx_ready_out,
	// Received words
	output logic                    rx_valid_out,
	output sap_rx_word_t            rx_word_out,
	// Link pins
	output logic                    master_clock_out,
	input  wire logic               serial_bit_clock_in,
	output logic                    serial_bit_clock_out,
	output logic                    serial_bit_clock_oe_out,
	input  wire logic               channel_select_line_in,
	output logic                    channel_select_line_out,
	output logic                    channel_select_line_oe_out,
	input  wire logic               serial_data_in,
	output logic                    serial_data_out
);
	// ==========================================
	// Declarations
	sap_sys_state_t     s_q, s_d;
	sap_link_state_t    l_q, l_d;
	sap_pins_t          pins_raw, pins_s;
	logic               run_s;
	logic               tgl_s;
	logic               fifo_valid;
	logic [`SAP_DW-1:0] fifo_data;
	logic               pop;
	logic               rise;
	logic               fall;
	logic               ws_now;
	logic               ws_chg;
	logic               xfer;
	logic [`SAP_DW-1:0] rx_new;
	logic [`SAP_DW-1:0] tx_al;

	// ==========================================
	// Crossings and buffer
	// Pins are synchronised before any link logic reads them
	assign pins_raw = '{sck: serial_bit_clock_in, ws: channel_select_line_in, sd: serial_data_in};
	sap_bit_sync #(.W(3)) u_pin_sync (
		.clk_in  (link_clk_in),
		.reset_in(reset_in),
		.d_in    (pins_raw),
		.q_out   (pins_s)
	);

	// Run level into the link domain
	sap_bit_sync #(.W(1)) u_run_sync (
		.clk_in  (link_clk_in),
		.reset_in(reset_in),
		.d_in    (s_q.run),
		.q_out   (run_s)
	);

	// Receive toggle into the system domain
	sap_bit_sync #(.W(1)) u_tgl_sync (
		.clk_in  (sys_clk_in),
		.reset_in(reset_in),
		.d_in    (l_q.rx_tgl),
		.q_out   (tgl_s)
	);

	// Transmit words cross through the dual clock buffer
	sap_fifo #(.W(`SAP_DW), .DEPTH(`SAP_FIFO_DEPTH), .AW(`SAP_FIFO_AW)) u_tx_fifo (
		.wr_clk_in   (sys_clk_in),
		.rd_clk_in   (link_clk_in),
		.reset_in    (reset_in),
		.wr_valid_in (tx_valid_in),
		.wr_data_in  (tx_data_in),
		.wr_ready_out(tx_ready_out),
		.rd_valid_out(fifo_valid),
		.rd_data_out (fifo_data),
		.rd_ready_in (pop)
	);

	// ==========================================
	// System domain
	// Configuration is taken only while stopped
	always_comb begin
		s_d = s_q;
		s_d.run = run_in;
		if (!run_in && !s_q.run) begin
			s_d.mode = mode_in; // RQ4
			s_d.len = word_length_field_in;
		end
		s_d.rx_valid = 1'b0;
		s_d.tgl_seen = tgl_s;
		if (tgl_s != s_q.tgl_seen) begin
			s_d.rx_valid = 1'b1;
			s_d.rx_word = l_q.rx_word;
		end
	end

	// System state register
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q <= '{mode: SAP_SLAVE, len: SAP_L16, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Link domain
	// Clock generation, framing, shifting
	always_comb begin
		l_d = l_q;
		rise = 1'b0;
		fall = 1'b0;
		ws_now = l_q.ws;
		ws_chg = 1'b0;
		pop = 1'b0;
		rx_new = {l_q.rx_sh[`SAP_DW-2:0], pins_s.sd};
		tx_al = '0;
		xfer = (l_q.mode != SAP_CTRL); // RQ2
		case (l_q.st)
			SAP_STOP: begin
				l_d.mode = s_q.mode; // RQ4
				l_d.len = sap_len_bits(s_q.len); // RQ8
				l_d.sck_oe = (s_q.mode != SAP_SLAVE); // RQ1 RQ3
				l_d.ws_oe = (s_q.mode != SAP_SLAVE);
				l_d.div = '0;
				l_d.mck = 1'b0;
				l_d.sck = 1'b0;
				l_d.ws = 1'b0;
				l_d.slot_cnt = '0;
				l_d.sd = 1'b0;
				l_d.tx_load = 1'b0;
				l_d.tx_sh = '0;
				l_d.rx_cnt = l_d.len;
				l_d.sck_p = pins_s.sck;
				l_d.ws_smp = (s_q.mode == SAP_SLAVE) ? pins_s.ws : 1'b0;
				if (run_s) begin
					l_d.st = SAP_RUN;
				end
			end
			SAP_RUN: begin
				if (l_q.mode != SAP_SLAVE) begin
					// Master clock at half, bit clock divided further
					l_d.mck = ~l_q.mck; // RQ1
					l_d.div = l_q.div + 4'h1;
					if (l_q.div == `SAP_DIV_LAST) begin
						l_d.div = '0;
						l_d.sck = ~l_q.sck; // RQ1
						rise = ~l_q.sck;
						fall = l_q.sck;
					end
					// Select changes on the falling edge after each slot
					if (fall) begin
						l_d.slot_cnt = l_q.slot_cnt + 6'h01;
						if (l_q.slot_cnt == `SAP_SLOT_LAST) begin
							l_d.slot_cnt = '0;
							l_d.ws = ~l_q.ws; // RQ1
						end
					end
				end else begin
					// Edges of the external clock
					l_d.sck_p = pins_s.sck; // RQ3
					rise = pins_s.sck & ~l_q.sck_p;
					fall = ~pins_s.sck & l_q.sck_p;
					ws_now = pins_s.ws;
				end
				// Receive side and slot start on the rising edge
				if (rise) begin
					ws_chg = (ws_now != l_q.ws_smp); // RQ10
					l_d.ws_smp = ws_now;
					if (ws_chg) begin
						l_d.rx_cnt = '0; // RQ5
						l_d.rx_right = ws_now; // RQ7
						l_d.rx_sh = '0;
						l_d.tx_load = 1'b1;
					end else if (l_q.rx_cnt < l_q.len) begin
						l_d.rx_sh = rx_new; // RQ6
						l_d.rx_cnt = l_q.rx_cnt + 6'h01;
						if (xfer && (l_q.rx_cnt + 6'h01 == l_q.len)) begin
							l_d.rx_word = '{right: l_q.rx_right, data: rx_new}; // RQ8
							l_d.rx_tgl = ~l_q.rx_tgl;
						end
					end
				end
				// Transmit side on the falling edge, MSB first, zero filled
				if (fall && xfer) begin
					if (l_q.tx_load) begin
						pop = fifo_valid;
						tx_al = fifo_valid ? fifo_data << (`SAP_WORD_BITS - l_q.len) : '0;
						l_d.sd = tx_al[`SAP_DW-1]; // RQ5
						l_d.tx_sh = tx_al << 1; // RQ9
						l_d.tx_load = 1'b0;
					end else begin
						l_d.sd = l_q.tx_sh[`SAP_DW-1]; // RQ6
						l_d.tx_sh = l_q.tx_sh << 1;
					end
				end
				if (!run_s) begin
					l_d.st = SAP_STOP;
				end
			end
			default: begin
				l_d.st = SAP_STOP;
			end
		endcase
	end

	// Link state register
	always_ff @(posedge link_clk_in or posedge reset_in) begin
		if (reset_in) begin
			l_q <= '{st: SAP_STOP, mode: SAP_SLAVE, len: `SAP_LEN_16, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	// ==========================================
	// Outputs
	assign rx_valid_out               = s_q.rx_valid;
	assign rx_word_out                = s_q.rx_word;
	assign master_clock_out           = l_q.mck;
	assign serial_bit_clock_out       = l_q.sck;
	assign serial_bit_clock_oe_out    = l_q.sck_oe;
	assign channel_select_line_out    = l_q.ws;
	assign channel_select_line_oe_out = l_q.ws_oe;
	assign serial_data_out            = l_q.sd;

	// ==========================================
	// Checks
	// Slot start followed by the first falling edge
	sequence s_slot_start;
		rise && ws_chg && xfer;
	endsequence
	sequence s_first_fall;
		fall && l_q.tx_load;
	endsequence

	AST_CLK_DRIVE: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ1
		(l_q.st == SAP_RUN && l_q.mode != SAP_SLAVE) |-> l_q.sck_oe && l_q.ws_oe)
		else $error("clock pins not driven in a generating mode");

	AST_CTRL_QUIET: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ2
		(l_q.mode == SAP_CTRL) |=> !pop && $stable(l_q.rx_tgl) && !l_q.sd)
		else $error("data moved in controller mode");

	AST_SLAVE_IN: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ3
		(l_q.st == SAP_RUN && l_q.mode == SAP_SLAVE) |-> !l_q.sck_oe && !l_q.ws_oe)
		else $error("clock pins driven in slave mode");

	AST_MODE_HOLD: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ4
		(l_q.st == SAP_RUN && l_d.st == SAP_RUN) |=> $stable(l_q.mode) && $stable(l_q.len))
		else $error("mode changed while running");

	AST_MSB_FIRST: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ5
		s_first_fall and (xfer && l_q.st == SAP_RUN) |=> l_q.sd == $past(tx_al[`SAP_DW-1]))
		else $error("first bit is not the word MSB");

	AST_LOAD_AFTER_WS: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ5
		s_slot_start |=> l_q.tx_load && l_q.rx_cnt == 6'h00)
		else $error("slot start not armed after select change");

	AST_TX_FALL: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ6
		(l_q.st == SAP_RUN && $changed(l_q.sd)) |-> $past(fall))
		else $error("data changed away from a falling edge");

	AST_RX_RISE: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ6
		$changed(l_q.rx_tgl) |-> $past(rise))
		else $error("word completed away from a rising edge");

	AST_CHANNEL: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ7
		(rise && ws_chg) |=> l_q.rx_right == $past(ws_now))
		else $error("channel does not follow select level");

	AST_LEN_BITS: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ8
		$changed(l_q.rx_tgl) |-> l_q.rx_cnt == l_q.len)
		else $error("word completed at wrong bit count");

	AST_DROP_EXTRA: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ9
		(rise && !ws_chg && l_q.rx_cnt == l_q.len) |=> $stable(l_q.rx_sh) && $stable(l_q.rx_tgl))
		else $error("extra received bit was kept");

	AST_WS_SAMPLE: assert property (@(posedge link_clk_in) disable iff (reset_in) // RQ10
		(l_q.st == SAP_RUN && $past(l_q.st) == SAP_RUN && $changed(l_q.ws_smp)) |-> $past(rise))
		else $error("select sampled away from a rising edge");
endmodule
`default_nettype wire

// file: sap_bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sap_bit_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// Level in and synchronised level out
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sap_sync_state_t;
	sap_sync_state_t r_q, r_d;

	// First stage feeds only the second
	always_comb begin
		r_d.s1 = d_in;
		r_d.s2 = r_q.s1;
	end

	// State register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign q_out = r_q.s2;
endmodule
`default_nettype wire

// file: sap_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module sap_codec_model #(
	parameter logic [31:0] LEFT_PAT  = 32'hA5C3_0F96,
	parameter logic [31:0] RIGHT_PAT = 32'h3C5A_96E1,
	parameter real         HALF_NS   = 1000.0
) (
	// Own clocks for slave operation
	input  wire logic        gen_in,
	output logic             sck_out,
	output logic             ws_out,
	// Link as seen on the wires
	input  wire logic        sck_in,
	input  wire logic        ws_in,
	input  wire logic        sd_in,
	output logic             sd_out,
	// Last complete slot words, index 0 is left
	output logic [31:0]      got_out [2],
	output int               slots_out
);
	int          gcnt = 0;
	int          cnt  = 40;
	logic        ws_p = 1'b0;
	logic [31:0] cap  = '0;

	// ==========================================
	// Clock source, still while not generating
	initial begin
		sck_out = 1'b0;
		ws_out = 1'b0;
		sd_out = 1'b0;
		got_out[0] = '0;
		got_out[1] = '0;
		slots_out = 0;
		forever begin
			#(HALF_NS);
			sck_out = gen_in ? ~sck_out : 1'b0;
			// Select flips on a falling edge every 32 bits
			if (gen_in && !sck_out) begin
				gcnt++;
				if (gcnt == 32) begin
					gcnt = 0;
					ws_out = ~ws_out;
				end
			end
		end
	end

	// ==========================================
	// Sample on rising edge; a select change opens a slot, MSB first
	always @(posedge sck_in) begin
		if (ws_in !== ws_p) begin
			got_out[ws_p] = cap;
			slots_out++;
			cap = '0;
			cnt = 0;
		end else if (cnt < 32) begin
			cnt++;
			cap[32-cnt] = sd_in;
		end
		ws_p = ws_in;
	end

	// Drive on falling edge by channel of the slot
	always @(negedge sck_in) begin
		sd_out <= (cnt < 32) ? (ws_p ? RIGHT_PAT[31-cnt] : LEFT_PAT[31-cnt]) : ~sd_out;
	end
endmodule
`default_nettype wire

// file: sap_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sap_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	// Clocks and reset
	input  wire logic         wr_clk_in,
	input  wire logic         rd_clk_in,
	input  wire logic         reset_in,
	// Fill side
	input  wire logic         wr_valid_in,
	input  wire logic [W-1:0] wr_data_in,
	output logic              wr_ready_out,
	// Drain side
	output logic              rd_valid_out,
	output logic      [W-1:0] rd_data_out,
	input  wire logic         rd_ready_in
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             bin;
		logic [AW:0]             gray;
		logic                    ready;
	} sap_fw_state_t;
	typedef struct packed {
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic        valid;
	} sap_fr_state_t;
	sap_fw_state_t w_q, w_d;
	sap_fr_state_t r_q, r_d;
	logic [AW:0] rgray_s, wgray_s, wbin_n, rbin_n;

	// Gray pointers cross in both directions
	sap_bit_sync #(.W(AW + 1)) u_rsync (.clk_in(wr_clk_in), .reset_in(reset_in),
		.d_in(r_q.gray), .q_out(rgray_s));
	sap_bit_sync #(.W(AW + 1)) u_wsync (.clk_in(rd_clk_in), .reset_in(reset_in),
		.d_in(w_q.gray), .q_out(wgray_s));

	// Write side: store, advance, registered not-full
	always_comb begin
		w_d = w_q;
		wbin_n = w_q.bin;
		if (wr_valid_in && w_q.ready) begin
			w_d.mem[w_q.bin[AW-1:0]] = wr_data_in;
			wbin_n = w_q.bin + 1'b1;
		end
		w_d.bin = wbin_n;
		w_d.gray = wbin_n ^ (wbin_n >> 1);
		w_d.ready = (w_d.gray != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
	end

	// Read side: advance, registered not-empty
	always_comb begin
		r_d = r_q;
		rbin_n = r_q.bin;
		if (rd_ready_in && r_q.valid) begin
			rbin_n = r_q.bin + 1'b1;
		end
		r_d.bin = rbin_n;
		r_d.gray = rbin_n ^ (rbin_n >> 1);
		r_d.valid = (r_d.gray != wgray_s);
	end

	// Write domain register
	always_ff @(posedge wr_clk_in or posedge reset_in) begin
		if (reset_in) begin
			w_q <= '0;
		end else begin
			w_q <= w_d;
		end
	end

	// Read domain register
	always_ff @(posedge rd_clk_in or posedge reset_in) begin
		if (reset_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign wr_ready_out = w_q.ready;
	assign rd_valid_out = r_q.valid;
	assign rd_data_out  = w_q.mem[r_q.bin[AW-1:0]];
endmodule
`default_nettype wire

// file: sap_params.svh
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH
// Behaviour
// RQ1 - Master and controller modes drive all clocks
// RQ2 - Controller mode keeps receiver and transmitter off
// RQ3 - Slave mode takes clock and select inputs
// RQ4 - Mode changes only while the port is stopped
// RQ5 - Left-justified MSB first, one clock after select
// RQ6 - Send on falling, sample on rising clock
// RQ7 - Select low is left, high is right
// RQ8 - Word length 8, 16, 18, 20, 24, 32
// RQ9 - Pad transmit with zeros, drop extra received bits
// RQ10 - Slave detects select changes on rising clock

// ==========================================
// Data path sizes
`define SAP_DW         32
`define SAP_FIFO_DEPTH 32
`define SAP_FIFO_AW    5
`define SAP_WORD_BITS  6'h20

// ==========================================
// Link timing: divider in link clock cycles, slot in bit clock cycles
`define SAP_DIV_LAST   4'h3
`define SAP_SLOT_LAST  6'h1F

// ==========================================
// Word length in bits per length code
`define SAP_LEN_8      6'h08
`define SAP_LEN_16     6'h10
`define SAP_LEN_18     6'h12
`define SAP_LEN_20     6'h14
`define SAP_LEN_24     6'h18
`define SAP_LEN_32     6'h20
`endif

// file: sap_pkg.sv
`include "sap_params.svh"
package sap_pkg;
	// ==========================================
	// Modes, lengths and states
	typedef enum logic [1:0] {SAP_MASTER = 2'b00, SAP_CTRL = 2'b01, SAP_SLAVE = 2'b10} sap_mode_t;
	typedef enum logic [2:0] {
		SAP_L8 = 3'h0, SAP_L16 = 3'h1, SAP_L18 = 3'h2,
		SAP_L20 = 3'h3, SAP_L24 = 3'h4, SAP_L32 = 3'h5
	} sap_len_t;
	typedef enum logic [1:0] {SAP_STOP = 2'b01, SAP_RUN = 2'b10} sap_run_st_t;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic                right;
		logic [`SAP_DW-1:0]  data;
	} sap_rx_word_t;
	typedef struct packed {
		logic sck;
		logic ws;
		logic sd;
	} sap_pins_t;

	// ==========================================
	// Module state
	typedef struct packed {
		logic         run;
		sap_mode_t    mode;
		sap_len_t     len;
		logic         tgl_seen;
		logic         rx_valid;
		sap_rx_word_t rx_word;
	} sap_sys_state_t;
	typedef struct packed {
		sap_run_st_t        st;
		sap_mode_t          mode;
		logic [5:0]         len;
		logic [3:0]         div;
		logic               mck;
		logic               sck;
		logic               ws;
		logic [5:0]         slot_cnt;
		logic               sck_oe;
		logic               ws_oe;
		logic               sd;
		logic               sck_p;
		logic               ws_smp;
		logic               tx_load;
		logic [`SAP_DW-1:0] tx_sh;
		logic [`SAP_DW-1:0] rx_sh;
		logic [5:0]         rx_cnt;
		logic               rx_right;
		sap_rx_word_t       rx_word;
		logic               rx_tgl;
	} sap_link_state_t;

	// Bits per word for a length code
	function automatic logic [5:0] sap_len_bits(input sap_len_t l);
		case (l)
			SAP_L8:  return `SAP_LEN_8;
			SAP_L16: return `SAP_LEN_16;
			SAP_L18: return `SAP_LEN_18;
			SAP_L20: return `SAP_LEN_20;
			SAP_L24: return `SAP_LEN_24;
			default: return `SAP_LEN_32;
		endcase
	endfunction
endpackage

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sap_pkg::*;
	localparam logic [31:0] LP  = 32'hA5C3_0F96;
	localparam logic [31:0] RP  = 32'h3C5A_96E1;
	localparam logic [31:0] TXL = 32'h0000_C3A5;
	localparam logic [31:0] TXR = 32'h0000_5A3C;
	logic         sys_clk_in = 1'b0;
	logic         link_clk   = 1'b0;
	logic         reset_in   = 1'b1;
	logic         run        = 1'b0;
	logic         tx_valid   = 1'b0;
	logic         gen        = 1'b0;
	sap_mode_t    mode       = SAP_SLAVE;
	sap_len_t     len        = SAP_L16;
	logic [31:0]  tx_data    = '0;
	logic         tx_ready, rx_valid, mck, sck_o, sck_oe, ws_o, ws_oe, sd_o;
	logic         m_sck, m_ws, m_sd, sd_hi;
	sap_rx_word_t rx_word;
	logic [31:0]  got [2];
	logic [31:0]  rx_last [2];
	int           slots, s0;
	int           rx_n = 0, sck_rises = 0, mck_rises = 0, fail_count = 0, num_checks = 0;
	wire logic    sck_w = sck_oe ? sck_o : m_sck;
	wire logic    ws_w  = ws_oe ? ws_o : m_ws;

	// ==========================================
	// Clocks
	always #5 sys_clk_in = ~sys_clk_in;
	initial begin
		#17;
		forever #62.5 link_clk = ~link_clk;
	end

	// ==========================================
	// Design and far side
	sap_audio_serial_unit u_dut (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(link_clk),
		.run_in(run), .mode_in(mode), .word_length_field_in(len),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
		.rx_valid_out(rx_valid), .rx_word_out(rx_word), .master_clock_out(mck),
		.serial_bit_clock_in(sck_w), .serial_bit_clock_out(sck_o),
		.serial_bit_clock_oe_out(sck_oe), .channel_select_line_in(ws_w),
		.channel_select_line_out(ws_o), .channel_select_line_oe_out(ws_oe),
		.serial_data_in(m_sd), .serial_data_out(sd_o)
	);
	sap_codec_model u_codec (
		.gen_in(gen), .sck_out(m_sck), .ws_out(m_ws), .sck_in(sck_w), .ws_in(ws_w),
		.sd_in(sd_o), .sd_out(m_sd), .got_out(got), .slots_out(slots)
	);

	// Watch received words, data line and clocks
	always @(posedge sys_clk_in) begin
		if (rx_valid === 1'b1) begin
			rx_last[rx_word.right] <= rx_word.data;
			rx_n <= rx_n + 1;
		end
		if (sd_o === 1'b1)
			sd_hi <= 1'b1;
	end
	always @(posedge sck_o) sck_rises++;
	always @(posedge mck) mck_rises++;

	// ==========================================
	// Shared tasks
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic check(input string what, input logic [32:0] exp, input logic [32:0] seen);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Stop, set mode and length, then run
	task automatic start(input sap_mode_t m, input sap_len_t l, input logic g);
		run <= 1'b0;
		wait_clk(4);
		mode <= m;
		len <= l;
		gen <= g;
		rx_last[0] <= '0;
		rx_last[1] <= '0;
		wait_clk(20);
		run <= 1'b1;
	endtask
	task automatic wait_slots(input int n);
		s0 = slots;
		for (int i = 0; i < 40000 && slots < s0 + n; i++)
			wait_clk(1);
	endtask
	task automatic finish_test();
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_fill();
		for (int i = 0; i < 33; i++) begin
			tx_valid <= 1'b1;
			// First armed slot after run is the right one, so the queue opens with right
			tx_data <= i[0] ? TXL : TXR;
			wait_clk(1);
		end
		tx_valid <= 1'b0;
		wait_clk(3);
		check("tx_ready when full", 33'h0, tx_ready);
	endtask
	task automatic t_ctrl();
		start(SAP_CTRL, SAP_L16, 1'b0);
		sd_hi <= 1'b0;
		sck_rises = 0;
		mck_rises = 0;
		wait_clk(2000);
		check("ctrl clock oe", 33'h1, sck_oe);
		check("ctrl select oe", 33'h1, ws_oe);
		check("ctrl bit clock runs", 33'h1, sck_rises > 8);
		check("ctrl master clock runs", 33'h1, mck_rises > 8);
		check("ctrl data line high", 33'h0, sd_hi);
		check("ctrl received words", 33'h0, rx_n);
		check("ctrl no pops", 33'h0, tx_ready);
	endtask
	task automatic t_master();
		start(SAP_MASTER, SAP_L16, 1'b0);
		wait_slots(5);
		check("master left out", {TXL[15:0], 16'h0} >> 1, got[0] >> 1);
		check("master right out", {TXR[15:0], 16'h0} >> 1, got[1] >> 1);
		check("master left in", LP >> 16, rx_last[0]);
		check("master right in", RP >> 16, rx_last[1]);
		check("master pops", 33'h1, tx_ready);
	endtask
	task automatic t_slave();
		start(SAP_SLAVE, SAP_L24, 1'b1);
		wait_slots(4);
		check("slave clock oe", 33'h0, sck_oe);
		check("slave select oe", 33'h0, ws_oe);
		check("slave left in", LP >> 8, rx_last[0]);
		check("slave right in", RP >> 8, rx_last[1]);
		run <= 1'b0;
		gen <= 1'b0;
	endtask

	// ==========================================
	// Main sequence and watchdog
	initial begin
		wait_clk(20);
		reset_in <= 1'b0;
		wait_clk(10);
		t_fill();
		t_ctrl();
		t_master();
		t_slave();
		finish_test();
	end
	initial begin
		wait_clk(95000);
		fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
